/* tapf_defs.svh */
`ifndef TAPF_DEFS_SVH
`define TAPF_DEFS_SVH

// ----------------------------------------------------------------
// configuration variable numbers
// ----------------------------------------------------------------
`define TAPF_CV_SHORT       10'h001
`define TAPF_CV_LONG_A      10'h011
`define TAPF_CV_LONG_B      10'h012
`define TAPF_CV_DEC_CFG     10'h01D
`define TAPF_CV_PROTO_EN    10'h02F
`define TAPF_CV_LEGACY_CFG  10'h031

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TAPF_RST_SHORT      8'h03
`define TAPF_RST_LONG_A     8'hC0
`define TAPF_RST_LONG_B     8'h80
`define TAPF_RST_DEC_CFG    8'h0C
`define TAPF_RST_PROTO_EN   8'h0F
`define TAPF_RST_LEGACY_CFG 8'h13
`define TAPF_RST_AUTO_ADDR  14'h0000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TAPF_BIT_LONG_SEL   5
`define TAPF_BIT_CONSEC_HI  7
`define TAPF_BIT_CONSEC_LO  3
`define TAPF_BIT_EN_DCC     0
`define TAPF_BIT_EN_AUTO    1
`define TAPF_BIT_EN_LEGACY  2
`define TAPF_BIT_EN_THIRD   3
`define TAPF_LONG_HI_W      6

// ----------------------------------------------------------------
// address ranges
// ----------------------------------------------------------------
`define TAPF_SHORT_MIN      14'h0001
`define TAPF_SHORT_MAX      14'h007F
`define TAPF_LONG_MIN       14'h0080
`define TAPF_LONG_MAX       14'h27FF

`endif

/* tapf_pkg.sv */
package tapf_pkg;

  // ----------------------------------------------------------------
  // protocols and packet kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    TAPF_DCC,
    TAPF_AUTO,
    TAPF_LEGACY,
    TAPF_THIRD,
    TAPF_PROG
  } tapf_proto_t;

  typedef enum logic [2:0]
  {
    TAPF_SPEED,
    TAPF_FUNC,
    TAPF_CV_WR,
    TAPF_CV_RD,
    TAPF_REGISTER
  } tapf_kind_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed
  {
    tapf_proto_t proto;
    tapf_kind_t  kind;
    logic [13:0] addr;
    logic [7:0]  speed;
    logic        dir;
    logic [4:0]  funcs;
    logic [9:0]  cv_num;
    logic [7:0]  cv_data;
  } tapf_pkt_t;

  typedef struct packed
  {
    logic [7:0] speed;
    logic       dir;
  } tapf_drive_t;

  typedef struct packed
  {
    logic [1:0] group;
    logic [4:0] bits;
  } tapf_func_t;

endpackage

/* tapf_addr_match.sv */
`timescale 1ns/100ps
`include "tapf_defs.svh"

module tapf_addr_match
(
  input  tapf_pkg::tapf_proto_t proto,
  input  wire logic [13:0]      addr,
  input  wire logic [7:0]       short_addr,
  input  wire logic [13:0]      long_addr,
  input  wire logic             long_sel,
  input  wire logic [1:0]       consec,
  input  wire logic [13:0]      auto_addr,
  input  wire logic             auto_known,
  output logic                  hit,
  output logic [1:0]            group
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [13:0] v,
                                    input logic [13:0] lo,
                                    input logic [13:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  logic [13:0] short_w;
  logic [13:0] diff;

  assign short_w = {6'h00, short_addr};
  assign diff    = addr - short_w;

  // ----------------------------------------------------------------
  // compare
  // ----------------------------------------------------------------
  always_comb
  begin
    hit   = 1'b0;
    group = 2'h0;
    case (proto)
      tapf_pkg::TAPF_DCC:
      begin
        if (long_sel)
          hit = in_range(long_addr, `TAPF_LONG_MIN, `TAPF_LONG_MAX)
                && (addr == long_addr);
        else
          hit = in_range(short_w, `TAPF_SHORT_MIN, `TAPF_SHORT_MAX)
                && (addr == short_w);
      end
      tapf_pkg::TAPF_LEGACY:
      begin
        if ((short_addr != 8'h00) && (addr >= short_w)
            && (diff <= {12'h000, consec}))
        begin
          hit   = 1'b1;
          group = diff[1:0];
        end
      end
      tapf_pkg::TAPF_AUTO:
        hit = auto_known && (addr == auto_addr);
      tapf_pkg::TAPF_THIRD:
        hit = (short_addr != 8'h00) && (addr == short_w);
      tapf_pkg::TAPF_PROG:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
  end

endmodule // tapf_addr_match

/* tapf_filter.sv */
`timescale 1ns/100ps
`include "tapf_defs.svh"

// What this block does
// - short address 1 to 127 is valid for DCC; legacy and third formats take any nonzero short address
// - decoder config bit five selects long address
// - long address 128 to 10239 from two CVs
// - legacy format shares short address, runs concurrently
// - legacy allows up to three extra addresses
// - extras follow base, carry higher function groups
// - speed and direction only from base address
// - legacy config bits seven, three count extras
// - extra addresses honoured only in legacy format
// - auto protocol address assigned, never read/written
// - protocol enable bits gate DCC, auto, legacy and third protocols
// - all protocols enabled after reset, value 15
// - writing protocol stays enabled on enable write
// - service programmer access can never be disabled
// - DCC-only variant ignores all enable bits, the DCC bit included
module tapf_filter
#(
  parameter bit DCC_ONLY = 1'b0
)
(
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic              PKT_VALID,
  input  tapf_pkg::tapf_pkt_t    PKT,
  output logic                   DRIVE_VALID,
  output tapf_pkg::tapf_drive_t  DRIVE,
  output logic                   FUNC_VALID,
  output tapf_pkg::tapf_func_t   FUNC,
  output logic                   CV_RD_VALID,
  output logic [7:0]             CV_RD_DATA,
  output logic                   PKT_DROP,
  output logic                   AUTO_REGISTERED,
  output logic                   LONG_MODE
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // mask of the enable bit that belongs to a protocol
  function automatic logic [7:0] proto_mask(
    input tapf_pkg::tapf_proto_t p);
    proto_mask = 8'h00;
    case (p)
      tapf_pkg::TAPF_DCC:    proto_mask[`TAPF_BIT_EN_DCC]    = 1'b1;
      tapf_pkg::TAPF_AUTO:   proto_mask[`TAPF_BIT_EN_AUTO]   = 1'b1;
      tapf_pkg::TAPF_LEGACY: proto_mask[`TAPF_BIT_EN_LEGACY] = 1'b1;
      tapf_pkg::TAPF_THIRD:  proto_mask[`TAPF_BIT_EN_THIRD]  = 1'b1;
      default:               proto_mask = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0]  short_ff;
  logic [7:0]  long_a_ff;
  logic [7:0]  long_b_ff;
  logic [7:0]  dec_cfg_ff;
  logic [7:0]  proto_en_ff;
  logic [7:0]  legacy_cfg_ff;
  logic [13:0] auto_addr_ff;
  logic        auto_known_ff;
  logic        drive_valid_ff;
  logic [7:0]  drive_speed_ff;
  logic        drive_dir_ff;
  logic        func_valid_ff;
  logic [1:0]  func_group_ff;
  logic [4:0]  func_bits_ff;
  logic        rd_valid_ff;
  logic [7:0]  rd_data_ff;
  logic        drop_ff;

  logic [13:0] long_addr;
  logic [1:0]  consec;
  logic        long_sel;
  logic        proto_on;
  logic        hit;
  logic [1:0]  group;
  logic        accept;
  logic        take_reg;
  logic        take_wr;
  logic        take_rd;
  logic        take_speed;
  logic        take_func;
  logic        used;
  logic [7:0]  nxt_rd_data;
  logic [7:0]  nxt_proto_en;
  logic [4:0]  nxt_func_bits;

  // ----------------------------------------------------------------
  // derived configuration
  // ----------------------------------------------------------------
  assign long_sel  = dec_cfg_ff[`TAPF_BIT_LONG_SEL];
  assign long_addr = {long_a_ff[`TAPF_LONG_HI_W-1:0], long_b_ff};
  assign consec    = {legacy_cfg_ff[`TAPF_BIT_CONSEC_HI],
                      legacy_cfg_ff[`TAPF_BIT_CONSEC_LO]};

  // ----------------------------------------------------------------
  // protocol gate
  // ----------------------------------------------------------------
  always_comb
  begin
    if (PKT.proto == tapf_pkg::TAPF_PROG)
      proto_on = 1'b1;
    else if (DCC_ONLY)
      proto_on = (PKT.proto == tapf_pkg::TAPF_DCC);
    else
      proto_on = |(proto_en_ff & proto_mask(PKT.proto));
  end

  // ----------------------------------------------------------------
  // address compare
  // ----------------------------------------------------------------
  tapf_addr_match u_match
  (
    .proto      (PKT.proto),
    .addr       (PKT.addr),
    .short_addr (short_ff),
    .long_addr  (long_addr),
    .long_sel   (long_sel),
    .consec     (consec),
    .auto_addr  (auto_addr_ff),
    .auto_known (auto_known_ff),
    .hit        (hit),
    .group      (group)
  );

  // ----------------------------------------------------------------
  // packet classification
  // ----------------------------------------------------------------
  assign accept     = PKT_VALID && proto_on && hit;
  assign take_reg   = PKT_VALID && proto_on
                      && (PKT.proto == tapf_pkg::TAPF_AUTO)
                      && (PKT.kind == tapf_pkg::TAPF_REGISTER);
  assign take_wr    = accept && (group == 2'h0)
                      && (PKT.kind == tapf_pkg::TAPF_CV_WR);
  assign take_rd    = accept && (group == 2'h0)
                      && (PKT.kind == tapf_pkg::TAPF_CV_RD);
  assign take_speed = accept && (group == 2'h0)
                      && (PKT.kind == tapf_pkg::TAPF_SPEED);
  assign take_func  = accept
                      && (PKT.kind == tapf_pkg::TAPF_FUNC);
  assign used       = take_reg || take_wr || take_rd
                      || take_speed || take_func;

  // ----------------------------------------------------------------
  // protocol enable write value
  // ----------------------------------------------------------------
  assign nxt_proto_en = PKT.cv_data | proto_mask(PKT.proto);

  // ----------------------------------------------------------------
  // short address register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      short_ff <= `TAPF_RST_SHORT;
    else if (take_wr && (PKT.cv_num == `TAPF_CV_SHORT))
      short_ff <= PKT.cv_data;
  end

  // ----------------------------------------------------------------
  // long address registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      long_a_ff <= `TAPF_RST_LONG_A;
      long_b_ff <= `TAPF_RST_LONG_B;
    end
    else if (take_wr && (PKT.cv_num == `TAPF_CV_LONG_A))
      long_a_ff <= PKT.cv_data;
    else if (take_wr && (PKT.cv_num == `TAPF_CV_LONG_B))
      long_b_ff <= PKT.cv_data;
  end

  // ----------------------------------------------------------------
  // decoder configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      dec_cfg_ff <= `TAPF_RST_DEC_CFG;
    else if (take_wr && (PKT.cv_num == `TAPF_CV_DEC_CFG))
      dec_cfg_ff <= PKT.cv_data;
  end

  // ----------------------------------------------------------------
  // protocol enable register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      proto_en_ff <= `TAPF_RST_PROTO_EN;
    else if (take_wr && (PKT.cv_num == `TAPF_CV_PROTO_EN))
      proto_en_ff <= nxt_proto_en;
  end

  // ----------------------------------------------------------------
  // legacy configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      legacy_cfg_ff <= `TAPF_RST_LEGACY_CFG;
    else if (take_wr && (PKT.cv_num == `TAPF_CV_LEGACY_CFG))
      legacy_cfg_ff <= PKT.cv_data;
  end

  // ----------------------------------------------------------------
  // auto-registering address
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      auto_addr_ff  <= `TAPF_RST_AUTO_ADDR;
      auto_known_ff <= 1'b0;
    end
    else if (take_reg)
    begin
      auto_addr_ff  <= PKT.addr;
      auto_known_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  always_comb
  begin
    if (PKT.cv_num == `TAPF_CV_SHORT)
      nxt_rd_data = short_ff;
    else if (PKT.cv_num == `TAPF_CV_LONG_A)
      nxt_rd_data = long_a_ff;
    else if (PKT.cv_num == `TAPF_CV_LONG_B)
      nxt_rd_data = long_b_ff;
    else if (PKT.cv_num == `TAPF_CV_DEC_CFG)
      nxt_rd_data = dec_cfg_ff;
    else if (PKT.cv_num == `TAPF_CV_PROTO_EN)
      nxt_rd_data = proto_en_ff;
    else if (PKT.cv_num == `TAPF_CV_LEGACY_CFG)
      nxt_rd_data = legacy_cfg_ff;
    else
      nxt_rd_data = 8'h00;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= 8'h00;
    end
    else
    begin
      rd_valid_ff <= take_rd;
      if (take_rd)
        rd_data_ff <= nxt_rd_data;
    end
  end

  // ----------------------------------------------------------------
  // drive command
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      drive_valid_ff <= 1'b0;
      drive_speed_ff <= 8'h00;
      drive_dir_ff   <= 1'b0;
    end
    else
    begin
      drive_valid_ff <= take_speed;
      if (take_speed)
      begin
        drive_speed_ff <= PKT.speed;
        drive_dir_ff   <= PKT.dir;
      end
    end
  end

  // ----------------------------------------------------------------
  // function command
  // ----------------------------------------------------------------
  // extra addresses carry four functions, no lighting function
  assign nxt_func_bits = (group == 2'h0) ? PKT.funcs
                                         : {1'b0, PKT.funcs[3:0]};

  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      func_valid_ff <= 1'b0;
      func_group_ff <= 2'h0;
      func_bits_ff  <= 5'h00;
    end
    else
    begin
      func_valid_ff <= take_func;
      if (take_func)
      begin
        func_group_ff <= group;
        func_bits_ff  <= nxt_func_bits;
      end
    end
  end

  // ----------------------------------------------------------------
  // discard indication
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      drop_ff <= 1'b0;
    else
      drop_ff <= PKT_VALID && !used;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign DRIVE_VALID     = drive_valid_ff;
  assign DRIVE.speed     = drive_speed_ff;
  assign DRIVE.dir       = drive_dir_ff;
  assign FUNC_VALID      = func_valid_ff;
  assign FUNC.group      = func_group_ff;
  assign FUNC.bits       = func_bits_ff;
  assign CV_RD_VALID     = rd_valid_ff;
  assign CV_RD_DATA      = rd_data_ff;
  assign PKT_DROP        = drop_ff;
  assign AUTO_REGISTERED = auto_known_ff;
  assign LONG_MODE       = long_sel;

endmodule // tapf_filter

/* tapf_filter_sva.sv */
`timescale 1ns/100ps
`include "tapf_defs.svh"

module tapf_filter_sva
#(
  parameter bit DCC_ONLY = 1'b0
)
(
  input wire logic             SYS_CLK,
  input wire logic             RST_N,
  input wire logic             PKT_VALID,
  input tapf_pkg::tapf_pkt_t   PKT,
  input wire logic             DRIVE_VALID,
  input tapf_pkg::tapf_drive_t DRIVE,
  input wire logic             FUNC_VALID,
  input tapf_pkg::tapf_func_t  FUNC,
  input wire logic             CV_RD_VALID,
  input wire logic [7:0]       CV_RD_DATA,
  input wire logic             PKT_DROP,
  input wire logic             AUTO_REGISTERED,
  input wire logic             LONG_MODE
);
  // ----------------------------
  // helpers
  // ----------------------------
  logic [3:0] ans;
  logic       spd;
  logic       wr29;

  assign ans = {DRIVE_VALID, FUNC_VALID, CV_RD_VALID, PKT_DROP};
  assign spd = PKT_VALID && PKT.proto == tapf_pkg::TAPF_DCC
               && PKT.kind == tapf_pkg::TAPF_SPEED;
  assign wr29 = PKT_VALID && PKT.kind == tapf_pkg::TAPF_CV_WR
                && PKT.cv_num == `TAPF_CV_DEC_CFG;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  // ----------------------------
  // checks
  // ----------------------------
  one_answer_a: assert property ($onehot0(ans))
    else $error("several answers at once");
  answer_due_a: assert property (PKT_VALID && PKT.kind !=
    tapf_pkg::TAPF_CV_WR && PKT.kind != tapf_pkg::TAPF_REGISTER
    |=> $onehot(ans)) else $error("packet left unanswered");
  idle_quiet_a: assert property (!PKT_VALID |=> ans == 4'h0)
    else $error("answer without packet");
  short_range_a: assert property (spd && !LONG_MODE &&
    (PKT.addr == 14'h0000 || PKT.addr > `TAPF_SHORT_MAX) |=> PKT_DROP)
    else $error("bad short address taken");
  long_only_a: assert property (spd && LONG_MODE &&
    PKT.addr < `TAPF_LONG_MIN |=> PKT_DROP)
    else $error("short address taken in long mode");
  long_range_a: assert property (spd && LONG_MODE &&
    PKT.addr > `TAPF_LONG_MAX |=> PKT_DROP)
    else $error("long address above range taken");
  drive_cause_a: assert property (DRIVE_VALID |->
    $past(PKT.kind) == tapf_pkg::TAPF_SPEED
    && DRIVE == {$past(PKT.speed), $past(PKT.dir)})
    else $error("drive not from a speed packet");
  extra_group_a: assert property (FUNC_VALID && FUNC.group != 2'h0
    |-> $past(PKT.proto) == tapf_pkg::TAPF_LEGACY && !FUNC.bits[4])
    else $error("extra group outside legacy format");
  prog_open_a: assert property (PKT_VALID && PKT.kind ==
    tapf_pkg::TAPF_CV_RD && PKT.proto == tapf_pkg::TAPF_PROG
    |=> CV_RD_VALID) else $error("programmer read refused");
  auto_gate_a: assert property (PKT_VALID && !AUTO_REGISTERED &&
    PKT.proto == tapf_pkg::TAPF_AUTO && PKT.kind == tapf_pkg::TAPF_SPEED
    |=> PKT_DROP) else $error("auto packet before registration");
  solo_dcc_a: assert property (DCC_ONLY && PKT_VALID &&
    PKT.proto inside {tapf_pkg::TAPF_AUTO, tapf_pkg::TAPF_LEGACY,
    tapf_pkg::TAPF_THIRD} |=> PKT_DROP)
    else $error("non dcc packet taken by dcc variant");
  mode_cause_a: assert property ($changed(LONG_MODE)
    |-> $past(wr29) || $past(wr29, 2))
    else $error("long mode moved without config write");

  cover property (DRIVE_VALID);
  cover property (FUNC_VALID && FUNC.group == 2'h3);
  cover property ($rose(AUTO_REGISTERED));
endmodule // tapf_filter_sva

bind tapf_filter tapf_filter_sva #(.DCC_ONLY(DCC_ONLY)) u_sva
(
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .PKT_VALID(PKT_VALID), .PKT(PKT),
  .DRIVE_VALID(DRIVE_VALID), .DRIVE(DRIVE), .FUNC_VALID(FUNC_VALID),
  .FUNC(FUNC), .CV_RD_VALID(CV_RD_VALID), .CV_RD_DATA(CV_RD_DATA),
  .PKT_DROP(PKT_DROP), .AUTO_REGISTERED(AUTO_REGISTERED),
  .LONG_MODE(LONG_MODE)
);

/* tapf_station.sv */
`timescale 1ns/100ps

module tapf_station
(
  input wire logic            sys_clk,
  output logic                pkt_valid,
  output tapf_pkg::tapf_pkt_t pkt
);
  // ----------------------------
  // packet sender
  // ----------------------------
  initial
  begin
    pkt_valid = 1'b0;
    pkt = '1;
  end

  // idle lines carry the inverse so no stale packet lingers
  task automatic send(input tapf_pkg::tapf_pkt_t p);
    @(negedge sys_clk);
    pkt_valid = 1'b1;
    pkt = p;
    @(negedge sys_clk);
    pkt_valid = 1'b0;
    pkt = ~p;
  endtask
endmodule // tapf_station

/* tapf_filter_test.sv */
`timescale 1ns/100ps
`include "tapf_defs.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end

module tapf_filter_test;
  // ----------------------------
  // signals and instances
  // ----------------------------
  localparam tapf_pkg::tapf_proto_t P_DCC = tapf_pkg::TAPF_DCC;
  localparam tapf_pkg::tapf_proto_t P_AUT = tapf_pkg::TAPF_AUTO;
  localparam tapf_pkg::tapf_proto_t P_LEG = tapf_pkg::TAPF_LEGACY;
  localparam tapf_pkg::tapf_proto_t P_THD = tapf_pkg::TAPF_THIRD;
  localparam tapf_pkg::tapf_kind_t  K_FUN = tapf_pkg::TAPF_FUNC;
  localparam logic [3:0]            DRV   = 4'h8;
  localparam logic [3:0]            DRP   = 4'h1;

  logic                  sys_clk;
  logic                  rst_n;
  logic                  pkt_valid;
  tapf_pkg::tapf_pkt_t   pkt;
  logic                  drive_valid;
  tapf_pkg::tapf_drive_t drive;
  logic                  func_valid;
  tapf_pkg::tapf_func_t  func;
  logic                  cv_rd_valid;
  logic [7:0]            cv_rd_data;
  logic                  pkt_drop;
  logic                  auto_registered;
  logic                  long_mode;
  logic                  solo_drop;
  logic [3:0]            answers;
  int                    fails;
  int                    total_checks;
  int                    i;
  int                    j;
  logic [7:0]            cnt_cfg [4] = '{8'h13, 8'h1B, 8'h93, 8'h9B};

  assign answers = {drive_valid, func_valid, cv_rd_valid, pkt_drop};

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  tapf_station STN (.sys_clk(sys_clk), .pkt_valid(pkt_valid), .pkt(pkt));
  tapf_filter #(.DCC_ONLY(1'b0)) DUT
  (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .PKT_VALID(pkt_valid), .PKT(pkt),
    .DRIVE_VALID(drive_valid), .DRIVE(drive), .FUNC_VALID(func_valid),
    .FUNC(func), .CV_RD_VALID(cv_rd_valid), .CV_RD_DATA(cv_rd_data),
    .PKT_DROP(pkt_drop), .AUTO_REGISTERED(auto_registered),
    .LONG_MODE(long_mode)
  );
  tapf_filter #(.DCC_ONLY(1'b1)) DUT_SOLO
  (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .PKT_VALID(pkt_valid), .PKT(pkt),
    .DRIVE_VALID(), .DRIVE(), .FUNC_VALID(), .FUNC(), .CV_RD_VALID(),
    .CV_RD_DATA(), .PKT_DROP(solo_drop), .AUTO_REGISTERED(), .LONG_MODE()
  );

  task automatic go(input tapf_pkg::tapf_proto_t p,
                    input tapf_pkg::tapf_kind_t k, input logic [13:0] a,
                    input logic [9:0] cv, input logic [7:0] d,
                    input logic [3:0] e);
    STN.send('{proto: p, kind: k, addr: a, speed: d, dir: d[0],
               funcs: d[4:0], cv_num: cv, cv_data: d});
    `CHK("answer", e, answers)
  endtask

  task automatic sp(input tapf_pkg::tapf_proto_t p, input logic [13:0] a,
                    input logic [3:0] e);
    go(p, tapf_pkg::TAPF_SPEED, a, 10'h000, 8'h5A, e);
  endtask

  task automatic wr(input logic [9:0] cv, input logic [7:0] d);
    go(tapf_pkg::TAPF_PROG, tapf_pkg::TAPF_CV_WR, 14'h0000, cv, d,
       4'h0);
  endtask

  task automatic rd(input logic [9:0] cv, input logic [7:0] e);
    go(tapf_pkg::TAPF_PROG, tapf_pkg::TAPF_CV_RD, 14'h0000, cv, 8'h00,
       4'h2);
    `CHK("cv_data", e, cv_rd_data)
  endtask

  task test_done;
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------
  // tests
  // ----------------------------
  initial
  begin
    fails = 0;
    total_checks = 0;
    rst_n = 1'b0;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    rd(`TAPF_CV_PROTO_EN, 8'h0F);
    rd(`TAPF_CV_LEGACY_CFG, 8'h13);
    rd(`TAPF_CV_SHORT, 8'h03);
    sp(P_DCC, 14'h0003, DRV);
    `CHK("drive", 9'h0B4, drive)
    sp(P_DCC, 14'h0004, DRP);
    sp(P_DCC, 14'h00C8, DRP);
    wr(`TAPF_CV_SHORT, 8'h7F);
    sp(P_DCC, 14'h007F, DRV);
    sp(P_LEG, 14'h007F, DRV);
    wr(`TAPF_CV_LONG_A, 8'hE7);
    wr(`TAPF_CV_LONG_B, 8'hFF);
    wr(`TAPF_CV_DEC_CFG, 8'h2C);
    sp(P_DCC, 14'h27FF, DRV);
    `CHK("long_mode", 1'b1, long_mode)
    sp(P_DCC, 14'h007F, DRP);
    sp(P_DCC, 14'h2800, DRP);
    sp(P_LEG, 14'h007F, DRV);
    wr(`TAPF_CV_DEC_CFG, 8'h0C);
    wr(`TAPF_CV_SHORT, 8'h32);
    for (i = 0; i < 4; i++)
    begin
      wr(`TAPF_CV_LEGACY_CFG, cnt_cfg[i]);
      for (j = 1; j < 4; j++)
        go(P_LEG, K_FUN, 14'(50 + j), 10'h000, 8'h1F,
           (j <= i) ? 4'h4 : DRP);
    end
    `CHK("func", 7'h6F, func)
    `CHK("solo", 1'b1, solo_drop)
    sp(P_LEG, 14'h0033, DRP);
    go(P_DCC, K_FUN, 14'h0033, 10'h000, 8'h1F, DRP);
    go(P_LEG, K_FUN, 14'h0032, 10'h000, 8'h1F, 4'h4);
    `CHK("func", 7'h1F, func)
    go(P_DCC, tapf_pkg::TAPF_CV_WR, 14'h0032, `TAPF_CV_PROTO_EN, 8'h00,
       4'h0);
    rd(`TAPF_CV_PROTO_EN, 8'h01);
    go(P_LEG, K_FUN, 14'h0032, 10'h000, 8'h01, DRP);
    sp(P_THD, 14'h0032, DRP);
    go(P_AUT, tapf_pkg::TAPF_REGISTER, 14'h1234, 10'h000, 8'h00,
       DRP);
    sp(P_DCC, 14'h0032, DRV);
    wr(`TAPF_CV_PROTO_EN, 8'h00);
    rd(`TAPF_CV_PROTO_EN, 8'h00);
    sp(P_DCC, 14'h0032, DRP);
    `CHK("solo_dcc", 1'b0, solo_drop)
    wr(`TAPF_CV_PROTO_EN, 8'h0F);
    sp(P_THD, 14'h0032, DRV);
    sp(P_AUT, 14'h1234, DRP);
    go(P_AUT, tapf_pkg::TAPF_REGISTER, 14'h1234, 10'h000, 8'h00,
       4'h0);
    `CHK("registered", 1'b1, auto_registered)
    sp(P_AUT, 14'h1234, DRV);
    sp(P_AUT, 14'h1235, DRP);
    test_done;
  end

  initial
  begin
    #100000;
    fails++;
    test_done;
  end
endmodule // tapf_filter_test
